/* logic/hag_map.svh */
// Purpose: register offsets, field positions, reset values and timing counts of the sensor link
// Assumes: 100 MHz system clock
// Notes: shared by both ends of the two-wire link
`ifndef HAG_MAP_SVH
`define HAG_MAP_SVH

`define HAG_REG_CONF 8'h00
`define HAG_REG_GAIN_SETUP 8'h01
`define HAG_REG_GAIN_CODE 8'h02
`define HAG_REG_BUS_ADDR 8'h03
`define HAG_REG_ANGLE_HI 8'h04
`define HAG_REG_ANGLE_LO 8'h05
`define HAG_REG_X_HI 8'h06
`define HAG_REG_X_LO 8'h07
`define HAG_REG_Y_HI 8'h08
`define HAG_REG_Y_LO 8'h09
`define HAG_REG_Z_HI 8'h0a
`define HAG_REG_Z_LO 8'h0b

`define HAG_CONF_RST 8'h00
`define HAG_GAIN_SETUP_RST 8'h00
`define HAG_GAIN_CODE_RST 8'h00
`define HAG_CONF_INT_EN_BIT 2
`define HAG_PAIR_XY 2'h0
`define HAG_PAIR_YZ 2'h1
`define HAG_PAIR_XZ 2'h2
`define HAG_PAIR_OFF 2'h3

// Upper five address bits; the two strap bits complete the factory address
`define HAG_FACTORY_BASE 5'h0d

`define HAG_ACK_BIT 4'h8
`define HAG_ANGLE_CALCULATOR_LAST 4'ha
`define HAG_HALF_TURN 14'sh0b40
`define HAG_FULL_TURN 14'sh1680

`define HAG_CLK_MHZ 100
`define HAG_INT_PULSE_NS 1000
`define HAG_INT_PULSE_CYC ((`HAG_INT_PULSE_NS * `HAG_CLK_MHZ + 999) / 1000)
`define HAG_SCL_PERIOD_NS 1000
`define HAG_SCL_QUARTER_CYC ((`HAG_SCL_PERIOD_NS * `HAG_CLK_MHZ) / 4000)

`endif

/* logic/hag_pkg.sv */
// Purpose: shared types of the sensor link
// Assumes: nothing
// Notes: numeric constants live in hag_map.svh
package hag_pkg;
  typedef logic [7:0] hag_byte_t;
  typedef logic signed [15:0] hag_axis_t;
  typedef enum logic [2:0] {
    HAG_ST_IDLE = 3'b000,
    HAG_ST_ADDR = 3'b001,
    HAG_ST_REG = 3'b010,
    HAG_ST_WDATA = 3'b011,
    HAG_ST_RDATA = 3'b100
  } hag_dev_state_t;
  typedef enum logic [2:0] {
    HAG_H_IDLE = 3'b000,
    HAG_H_START = 3'b001,
    HAG_H_TX = 3'b010,
    HAG_H_RX = 3'b011,
    HAG_H_STOP = 3'b100
  } hag_host_state_t;
endpackage

/* logic/hag_link_if.sv */
// Purpose: two-wire bus plus open-drain interrupt line between host and sensor
// Assumes: open-drain wires pulled high when nobody drives
// Notes: each enable high pulls its wire low
`timescale 1ns/1ps
interface hag_link_if;
  logic host_scl_oe;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic dev_int_oe;
  logic scl;
  logic sda;
  logic int_n;
  assign scl = ~host_scl_oe;
  assign sda = ~(host_sda_oe | dev_sda_oe);
  assign int_n = ~dev_int_oe;
  modport dev (input scl, input sda, output dev_sda_oe, output dev_int_oe);
  modport host (input sda, input int_n, output host_scl_oe, output host_sda_oe);
endinterface

/* logic/hag_device.sv */
// Purpose: sensor end: two-wire register slave, gain normalisation, angle calculator
// Assumes: sample_valid_in marks a finished conversion of x_in, y_in, z_in
// Notes: angle is in 1/16 degree, 0 to 5759 for a full turn
//
// Summary of operation
// - Angle uses the software-selected axis pair
// - Angle covers the full 360 degree circle
// - Gain is code over 256, scaling one axis
// - Gain target bit 0 scales X, 1 Y
// - Host calibrates gain on larger-amplitude axis
// - Factory address at power-up, software may replace
// - Bus address field is seven bits wide
// - Reset restores factory address; host reassigns
// - Host powers sensors singly, then assigns address
// - Shared interrupt: host reads every sensor
// - Results update only when a conversion completes
// - Interrupt on completion paces host result reads
`timescale 1ns/1ps
`include "hag_map.svh"
module hag_device (
  input wire logic clock_in,
  input wire logic rst_in,
  hag_link_if.dev link,
  input wire logic [1:0] factory_sel_in,
  input wire logic sample_valid_in,
  input wire hag_pkg::hag_axis_t x_in,
  input wire hag_pkg::hag_axis_t y_in,
  input wire hag_pkg::hag_axis_t z_in,
  output logic [15:0] angle_out,
  output logic result_valid_out,
  output logic [6:0] bus_addr_out
);
  import hag_pkg::*;

  localparam int INT_CYC = `HAG_INT_PULSE_CYC;

  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic scl_rise, scl_fall, start_det, stop_det;
  hag_dev_state_t st_r;
  logic [3:0] bit_cnt_r;
  hag_byte_t shift_r, rd_sh_r, ptr_r, rd_val;
  logic sda_oe_r, wr_stb, strap_pend_r;
  hag_byte_t conf_r, gain_setup_r, gain_code_r;
  hag_axis_t res_x_r, res_y_r, res_z_r, cap_x_r, cap_y_r, cap_z_r;
  hag_axis_t gx, gy, a_w, b_w;
  logic signed [17:0] ca_r, cb_r, a_ext, b_ext;
  logic signed [13:0] cz_r;
  logic [3:0] it_r;
  logic busy_r, fin_r;
  logic [1:0] pair_r;
  logic [7:0] int_cnt_r;
  logic int_oe_r;

  // Link pins cross into the clock domain before any logic reads them
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s1 <= link.scl;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_det = scl_s2 & scl_d & ~sda_d & sda_s2;
  assign wr_stb = scl_fall && (bit_cnt_r == `HAG_ACK_BIT) && (st_r == HAG_ST_WDATA);

  // Byte-level slave: address match, register pointer, writes and reads
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_r <= HAG_ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      rd_sh_r <= 8'h00;
      ptr_r <= 8'h00;
      sda_oe_r <= 1'b0;
    end else if (start_det) begin
      st_r <= HAG_ST_ADDR;
      bit_cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (stop_det) begin
      st_r <= HAG_ST_IDLE;
      sda_oe_r <= 1'b0;
    end else if (st_r != HAG_ST_IDLE && scl_rise) begin
      if (bit_cnt_r == `HAG_ACK_BIT) begin
        bit_cnt_r <= 4'h0;
        if (st_r == HAG_ST_RDATA && sda_s2) begin
          st_r <= HAG_ST_IDLE;
        end
      end else begin
        shift_r <= {shift_r[6:0], sda_s2};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
    end else if (st_r != HAG_ST_IDLE && scl_fall) begin
      if (bit_cnt_r == `HAG_ACK_BIT) begin
        case (st_r)
          HAG_ST_ADDR: begin
            if (shift_r[7:1] == bus_addr_out) begin
              sda_oe_r <= 1'b1;
              st_r <= shift_r[0] ? HAG_ST_RDATA : HAG_ST_REG;
            end else begin
              st_r <= HAG_ST_IDLE;
            end
          end
          HAG_ST_REG: begin
            ptr_r <= shift_r;
            sda_oe_r <= 1'b1;
            st_r <= HAG_ST_WDATA;
          end
          HAG_ST_WDATA: begin
            ptr_r <= ptr_r + 8'h01;
            sda_oe_r <= 1'b1;
          end
          default: begin
            ptr_r <= ptr_r + 8'h01;
            sda_oe_r <= 1'b0;
          end
        endcase
      end else if (st_r == HAG_ST_RDATA) begin
        if (bit_cnt_r == 4'h0) begin
          rd_sh_r <= {rd_val[6:0], 1'b0};
          sda_oe_r <= ~rd_val[7];
        end else begin
          rd_sh_r <= {rd_sh_r[6:0], 1'b0};
          sda_oe_r <= ~rd_sh_r[7];
        end
      end else begin
        sda_oe_r <= 1'b0;
      end
    end
  end

  // Bus address: factory strap after reset, software may replace it
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      strap_pend_r <= 1'b1;
      bus_addr_out <= {`HAG_FACTORY_BASE, 2'h0};
    end else if (strap_pend_r) begin
      strap_pend_r <= 1'b0;
      bus_addr_out <= {`HAG_FACTORY_BASE, factory_sel_in};
    end else if (wr_stb && ptr_r == `HAG_REG_BUS_ADDR) begin
      bus_addr_out <= shift_r[6:0];
    end
  end

  // Writable configuration
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      conf_r <= `HAG_CONF_RST;
      gain_setup_r <= `HAG_GAIN_SETUP_RST;
      gain_code_r <= `HAG_GAIN_CODE_RST;
    end else if (wr_stb) begin
      case (ptr_r)
        `HAG_REG_CONF: conf_r <= shift_r;
        `HAG_REG_GAIN_SETUP: gain_setup_r <= shift_r;
        `HAG_REG_GAIN_CODE: gain_code_r <= shift_r;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (ptr_r)
      `HAG_REG_CONF: rd_val = conf_r;
      `HAG_REG_GAIN_SETUP: rd_val = gain_setup_r;
      `HAG_REG_GAIN_CODE: rd_val = gain_code_r;
      `HAG_REG_BUS_ADDR: rd_val = {1'b0, bus_addr_out};
      `HAG_REG_ANGLE_HI: rd_val = angle_out[15:8];
      `HAG_REG_ANGLE_LO: rd_val = angle_out[7:0];
      `HAG_REG_X_HI: rd_val = res_x_r[15:8];
      `HAG_REG_X_LO: rd_val = res_x_r[7:0];
      `HAG_REG_Y_HI: rd_val = res_y_r[15:8];
      `HAG_REG_Y_LO: rd_val = res_y_r[7:0];
      `HAG_REG_Z_HI: rd_val = res_z_r[15:8];
      `HAG_REG_Z_LO: rd_val = res_z_r[7:0];
      default: rd_val = 8'h00;
    endcase
  end

  function automatic hag_axis_t scale(input hag_axis_t v, input hag_byte_t g);
    logic signed [24:0] p;
    p = v * $signed({1'b0, g});
    return p[23:8];
  endfunction

  function automatic logic signed [13:0] atan_step(input logic [3:0] i);
    case (i)
      4'h0: atan_step = 14'sh02d0;
      4'h1: atan_step = 14'sh01a9;
      4'h2: atan_step = 14'sh00e1;
      4'h3: atan_step = 14'sh0072;
      4'h4: atan_step = 14'sh0039;
      4'h5: atan_step = 14'sh001d;
      4'h6: atan_step = 14'sh000e;
      4'h7: atan_step = 14'sh0007;
      4'h8: atan_step = 14'sh0004;
      4'h9: atan_step = 14'sh0002;
      default: atan_step = 14'sh0001;
    endcase
  endfunction

  // Gain on one axis, then pick the pair that feeds the angle calculator
  always_comb begin
    gx = x_in;
    gy = y_in;
    if (gain_code_r != 8'h00) begin
      if (gain_setup_r[0]) begin
        gy = scale(y_in, gain_code_r);
      end else begin
        gx = scale(x_in, gain_code_r);
      end
    end
    case (conf_r[1:0])
      `HAG_PAIR_YZ: begin
        a_w = gy;
        b_w = z_in;
      end
      `HAG_PAIR_XZ: begin
        a_w = gx;
        b_w = z_in;
      end
      default: begin
        a_w = gx;
        b_w = gy;
      end
    endcase
  end

  assign a_ext = {{2{a_w[15]}}, a_w};
  assign b_ext = {{2{b_w[15]}}, b_w};

  // Vectoring angle calculator; left half plane folded by a half turn first
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      busy_r <= 1'b0;
      fin_r <= 1'b0;
      it_r <= 4'h0;
      ca_r <= 18'sh00000;
      cb_r <= 18'sh00000;
      cz_r <= 14'sh0000;
      pair_r <= `HAG_PAIR_XY;
      cap_x_r <= 16'sh0000;
      cap_y_r <= 16'sh0000;
      cap_z_r <= 16'sh0000;
    end else begin
      fin_r <= 1'b0;
      if (!busy_r && sample_valid_in) begin
        busy_r <= 1'b1;
        it_r <= 4'h0;
        pair_r <= conf_r[1:0];
        cap_x_r <= x_in;
        cap_y_r <= y_in;
        cap_z_r <= z_in;
        if (a_w < 0) begin
          ca_r <= -a_ext;
          cb_r <= -b_ext;
          cz_r <= `HAG_HALF_TURN;
        end else begin
          ca_r <= a_ext;
          cb_r <= b_ext;
          cz_r <= 14'sh0000;
        end
      end else if (busy_r) begin
        if (cb_r >= 0) begin
          ca_r <= ca_r + (cb_r >>> it_r);
          cb_r <= cb_r - (ca_r >>> it_r);
          cz_r <= cz_r + atan_step(it_r);
        end else begin
          ca_r <= ca_r - (cb_r >>> it_r);
          cb_r <= cb_r + (ca_r >>> it_r);
          cz_r <= cz_r - atan_step(it_r);
        end
        it_r <= it_r + 4'h1;
        if (it_r == `HAG_ANGLE_CALCULATOR_LAST) begin
          busy_r <= 1'b0;
          fin_r <= 1'b1;
        end
      end
    end
  end

  // Axis results change together, only when a conversion has finished; angle held when the pair is off
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      angle_out <= 16'h0000;
      res_x_r <= 16'sh0000;
      res_y_r <= 16'sh0000;
      res_z_r <= 16'sh0000;
      result_valid_out <= 1'b0;
    end else begin
      result_valid_out <= fin_r;
      if (fin_r) begin
        res_x_r <= cap_x_r;
        res_y_r <= cap_y_r;
        res_z_r <= cap_z_r;
        if (pair_r != `HAG_PAIR_OFF) begin
          angle_out <= {2'b00, (cz_r < 0) ? cz_r + `HAG_FULL_TURN : cz_r};
        end
      end
    end
  end

  // Interrupt pulse pulls the shared line low once results are fresh
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      int_cnt_r <= 8'h00;
      int_oe_r <= 1'b0;
    end else if (fin_r && conf_r[`HAG_CONF_INT_EN_BIT]) begin
      int_cnt_r <= 8'(INT_CYC - 1);
      int_oe_r <= 1'b1;
    end else if (int_cnt_r != 8'h00) begin
      int_cnt_r <= int_cnt_r - 8'h01;
    end else begin
      int_oe_r <= 1'b0;
    end
  end

  assign link.dev_sda_oe = sda_oe_r;
  assign link.dev_int_oe = int_oe_r;
endmodule // hag_device

/* logic/hag_host.sv */
// Purpose: bus primary: one register write or read per command on the two-wire link
// Assumes: the sensor never stretches the clock
// Notes: a read sends the register index, a repeated start, then reads one byte
`timescale 1ns/1ps
`include "hag_map.svh"
module hag_host #(
  parameter int QUARTER_CYC = `HAG_SCL_QUARTER_CYC
) (
  input wire logic clock_in,
  input wire logic rst_in,
  hag_link_if.host link,
  input wire logic cmd_valid_in,
  input wire logic cmd_read_in,
  input wire logic [6:0] dev_addr_in,
  input wire hag_pkg::hag_byte_t reg_in,
  input wire hag_pkg::hag_byte_t wdata_in,
  output logic cmd_ready_out,
  output logic done_out,
  output logic nack_out,
  output hag_pkg::hag_byte_t rdata_out,
  output logic int_seen_out
);
  import hag_pkg::*;

  hag_host_state_t st_r;
  logic [15:0] div_r;
  logic tick;
  logic [1:0] q_r;
  logic [3:0] bit_r;
  logic [2:0] step_r;
  logic rd_r, scl_oe_r, sda_oe_r, sda_s1, sda_s2, int_s1;
  logic [6:0] addr_r;
  hag_byte_t reg_r, wd_r, tx_r, rx_r;

  // Divider: one enable pulse per quarter of the bus clock period
  always_ff @(posedge clock_in) begin
    if (rst_in || st_r == HAG_H_IDLE) begin
      div_r <= 16'h0000;
    end else if (div_r == 16'(QUARTER_CYC - 1)) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end
  assign tick = (st_r != HAG_H_IDLE) && (div_r == 16'(QUARTER_CYC - 1));

  // Pin inputs pass two flip-flops; the interrupt is shown for the user to pace reads
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      int_s1 <= 1'b1;
      int_seen_out <= 1'b0;
    end else begin
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
      int_s1 <= link.int_n;
      int_seen_out <= ~int_s1;
    end
  end

  // Byte to send at each step: write is A+W, reg, data; read is A+W, reg, A+R
  always_comb begin
    case (step_r)
      3'h1: tx_r = {addr_r, 1'b0};
      3'h2: tx_r = reg_r;
      3'h3: tx_r = rd_r ? {addr_r, 1'b1} : wd_r;
      default: tx_r = 8'h00;
    endcase
  end

  // Address assignment after power-up is a plain write to the address register
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_r <= HAG_H_IDLE;
      q_r <= 2'h0;
      bit_r <= 4'h0;
      step_r <= 3'h0;
      rd_r <= 1'b0;
      addr_r <= 7'h00;
      reg_r <= 8'h00;
      wd_r <= 8'h00;
      rx_r <= 8'h00;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      cmd_ready_out <= 1'b0;
      done_out <= 1'b0;
      nack_out <= 1'b0;
      rdata_out <= 8'h00;
    end else begin
      done_out <= 1'b0;
      case (st_r)
        HAG_H_IDLE: begin
          cmd_ready_out <= 1'b1;
          if (cmd_valid_in && cmd_ready_out) begin
            cmd_ready_out <= 1'b0;
            rd_r <= cmd_read_in;
            addr_r <= dev_addr_in;
            reg_r <= reg_in;
            wd_r <= wdata_in;
            nack_out <= 1'b0;
            step_r <= 3'h1;
            q_r <= 2'h0;
            st_r <= HAG_H_START;
          end
        end
        HAG_H_START: if (tick) begin
          q_r <= q_r + 2'h1;
          scl_oe_r <= (q_r == 2'h3);
          sda_oe_r <= (q_r != 2'h0);
          if (q_r == 2'h3) begin
            bit_r <= 4'h0;
            st_r <= HAG_H_TX;
          end
        end
        HAG_H_TX, HAG_H_RX: if (tick) begin
          q_r <= q_r + 2'h1;
          // SCL low for two quarters so SDA moves mid-low, never at the rising edge
          scl_oe_r <= (q_r == 2'h3) || (q_r == 2'h0);
          if (q_r == 2'h3 && bit_r == `HAG_ACK_BIT) begin
            if (st_r == HAG_H_RX) begin
              rdata_out <= rx_r;
              st_r <= HAG_H_STOP;
            end else if (sda_s2) begin
              nack_out <= 1'b1;
              st_r <= HAG_H_STOP;
            end else if (rd_r && step_r == 3'h2) begin
              step_r <= 3'h3;
              st_r <= HAG_H_START;
            end else if (rd_r && step_r == 3'h3) begin
              bit_r <= 4'h0;
              st_r <= HAG_H_RX;
            end else if (step_r == 3'h3) begin
              st_r <= HAG_H_STOP;
            end else begin
              step_r <= step_r + 3'h1;
              bit_r <= 4'h0;
            end
          end else if (q_r == 2'h3) begin
            rx_r <= {rx_r[6:0], sda_s2};
            bit_r <= bit_r + 4'h1;
          end else if (q_r == 2'h0) begin
            sda_oe_r <= (st_r == HAG_H_TX) && (bit_r != `HAG_ACK_BIT) && !tx_r[3'(7 - bit_r)];
          end
        end
        HAG_H_STOP: if (tick) begin
          q_r <= q_r + 2'h1;
          scl_oe_r <= (q_r == 2'h0);
          sda_oe_r <= (q_r != 2'h3) && (q_r != 2'h2);
          if (q_r == 2'h3) begin
            sda_oe_r <= 1'b0;
            done_out <= 1'b1;
            st_r <= HAG_H_IDLE;
          end
        end
        default: st_r <= HAG_H_IDLE;
      endcase
    end
  end

  assign link.host_scl_oe = scl_oe_r;
  assign link.host_sda_oe = sda_oe_r;
endmodule // hag_host

/* test/hag_link_props.sv */
// Purpose: wire-level checks on the two-wire link and the interrupt line
// Assumes: one clock domain, synchronous active-high reset held two cycles
// Notes: sees only the interface signals
`timescale 1ns/1ps
module hag_link_props #(
  parameter int INT_CYC = 100
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic dev_int_oe,
  input wire logic scl,
  input wire logic sda,
  input wire logic int_n
);
  logic [7:0] int_cnt_r;
  logic held_hi_r;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // Length of the current interrupt pulse
  always_ff @(posedge clock_in) begin
    if (rst_in || !dev_int_oe) begin
      int_cnt_r <= 8'h00;
    end else if (int_cnt_r != 8'hff) begin
      int_cnt_r <= int_cnt_r + 8'h01;
    end
  end
  // Device has held SDA through an SCL high phase
  always_ff @(posedge clock_in) begin
    if (rst_in || !dev_sda_oe) begin
      held_hi_r <= 1'b0;
    end else if (scl) begin
      held_hi_r <= 1'b1;
    end
  end
  sequence start_cond;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stop_cond;
    scl && $past(scl) && $rose(sda);
  endsequence
  a_reset_lines_free: assert property ($fell(rst_in) |->
    !dev_sda_oe && !dev_int_oe && !host_scl_oe && !host_sda_oe)
    else $error("line pulled right after reset");
  a_int_pulse_len: assert property ($fell(dev_int_oe) |-> int_cnt_r == INT_CYC)
    else $error("interrupt pulse length off");
  a_int_bounded: assert property (int_cnt_r <= INT_CYC)
    else $error("interrupt pulse too long");
  a_int_low_run: assert property ($rose(dev_int_oe) |-> !int_n [*8])
    else $error("interrupt line not held low");
  a_dev_sda_timing: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device changed SDA while SCL high");
  a_dev_ack_held: assert property ($fell(dev_sda_oe) |-> $past(held_hi_r))
    else $error("device released SDA before SCL high");
  a_start_by_host: assert property (start_cond |-> $rose(host_sda_oe))
    else $error("start not made by host");
  a_stop_by_host: assert property (stop_cond |-> $fell(host_sda_oe) && !dev_sda_oe)
    else $error("stop not made by host");
  c_int_seen: cover property ($fell(dev_int_oe));
endmodule // hag_link_props

/* test/hall_angle_gain_and_addressing_bench.sv */
// Purpose: end-to-end bench of host and sensor over the two-wire link
// Assumes: QUARTER_CYC of 4, factory strap 2'b10
// Notes: angles compared within half a degree
`timescale 1ns/1ps
`include "hag_map.svh"
module hall_angle_gain_and_addressing_bench;
  import hag_pkg::*;
  typedef struct packed {
    logic [1:0] pair;
    logic tgt;
    logic [7:0] code;
    logic [15:0] x, y, z, ang;
  } hag_case_t;
  localparam logic [6:0] FACTORY = {`HAG_FACTORY_BASE, 2'b10};
  logic clock_in, rst_in, cmd_valid_in, cmd_read_in, cmd_ready_out, done_out, nack_out;
  logic int_seen_out, sample_valid_in, result_valid_out, seen;
  logic [1:0] factory_sel_in;
  logic [6:0] dev_addr_in, bus_addr_out;
  hag_byte_t reg_in, wdata_in, rdata_out, hi;
  hag_axis_t x_in, y_in, z_in;
  logic [15:0] angle_out;
  hag_case_t cases [10];
  hag_byte_t regs [5];
  hag_byte_t rexp [5];
  int miscompares, tests_run, cycles;
  hag_link_if link_if ();
  hag_host #(.QUARTER_CYC(4)) hag_host_i (.clock_in(clock_in), .rst_in(rst_in),
    .link(link_if.host), .cmd_valid_in(cmd_valid_in), .cmd_read_in(cmd_read_in),
    .dev_addr_in(dev_addr_in), .reg_in(reg_in), .wdata_in(wdata_in),
    .cmd_ready_out(cmd_ready_out), .done_out(done_out), .nack_out(nack_out),
    .rdata_out(rdata_out), .int_seen_out(int_seen_out));
  hag_device hag_device_i (.clock_in(clock_in), .rst_in(rst_in), .link(link_if.dev),
    .factory_sel_in(factory_sel_in), .sample_valid_in(sample_valid_in), .x_in(x_in),
    .y_in(y_in), .z_in(z_in), .angle_out(angle_out), .result_valid_out(result_valid_out),
    .bus_addr_out(bus_addr_out));
  hag_link_props hag_link_props_i (.clock_in(clock_in), .rst_in(rst_in),
    .host_scl_oe(link_if.host_scl_oe), .host_sda_oe(link_if.host_sda_oe),
    .dev_sda_oe(link_if.dev_sda_oe), .dev_int_oe(link_if.dev_int_oe),
    .scl(link_if.scl), .sda(link_if.sda), .int_n(link_if.int_n));

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Angles wrap at a full turn of 5760
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input int tol);
    int d;
    logic bad;
    tests_run++;
    d = int'(got) - int'(exp);
    if (d > 2880) d -= 5760;
    if (d < -2880) d += 5760;
    bad = (tol == 0) ? (got !== exp) : ((^got) === 1'bx || d > tol || d < -tol);
    if (bad) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic rd, input logic [6:0] a, input hag_byte_t rg,
                      input hag_byte_t wd, input logic nk);
    int n;
    n = 0;
    @(negedge clock_in);
    while (cmd_ready_out !== 1'b1 && n < 300) begin
      @(negedge clock_in);
      n++;
    end
    @(posedge clock_in);
    cmd_valid_in <= 1'b1;
    cmd_read_in <= rd;
    dev_addr_in <= a;
    reg_in <= rg;
    wdata_in <= wd;
    @(posedge clock_in);
    cmd_valid_in <= 1'b0;
    n = 0;
    @(negedge clock_in);
    while (done_out !== 1'b1 && n < 2000) begin
      @(negedge clock_in);
      n++;
    end
    chk({15'h0000, done_out}, 16'h0001, 0);
    chk({15'h0000, nack_out}, {15'h0000, nk}, 0);
  endtask

  task automatic sample(input hag_axis_t x, input hag_axis_t y, input hag_axis_t z);
    @(posedge clock_in);
    x_in <= x;
    y_in <= y;
    z_in <= z;
    sample_valid_in <= 1'b1;
    @(posedge clock_in);
    sample_valid_in <= 1'b0;
    seen = 1'b0;
    repeat (30) begin
      @(negedge clock_in);
      if (result_valid_out === 1'b1) seen = 1'b1;
    end
  endtask

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 80000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    rst_in = 1'b1;
    cmd_valid_in = 1'b0;
    cmd_read_in = 1'b0;
    dev_addr_in = 7'h00;
    reg_in = 8'h00;
    wdata_in = 8'h00;
    factory_sel_in = 2'b10;
    sample_valid_in = 1'b0;
    x_in = 16'h0000;
    y_in = 16'h0000;
    z_in = 16'h0000;
    regs = '{`HAG_REG_CONF, `HAG_REG_GAIN_SETUP, `HAG_REG_GAIN_CODE, `HAG_REG_BUS_ADDR, 8'h20};
    rexp = '{8'h00, 8'h00, 8'h00, {1'b0, FACTORY}, 8'h00};
    cases[0] = '{2'h0, 1'b0, 8'h00, 16'h03e8, 16'h0000, 16'hfc18, 16'h0000};
    cases[1] = '{2'h0, 1'b0, 8'h00, 16'h0000, 16'h03e8, 16'hfc18, 16'h05a0};
    cases[2] = '{2'h0, 1'b0, 8'h00, 16'hfc18, 16'h0000, 16'h03e8, 16'h0b40};
    cases[3] = '{2'h0, 1'b0, 8'h00, 16'h0000, 16'hfc18, 16'h03e8, 16'h10e0};
    cases[4] = '{2'h1, 1'b0, 8'h00, 16'hfc18, 16'h0000, 16'h03e8, 16'h05a0};
    cases[5] = '{2'h2, 1'b0, 8'h00, 16'h0000, 16'h03e8, 16'hfc18, 16'h10e0};
    cases[6] = '{2'h0, 1'b0, 8'h00, 16'h03e8, 16'h01f4, 16'h0000, 16'h01a9};
    cases[7] = '{2'h0, 1'b0, 8'h80, 16'h03e8, 16'h01f4, 16'h0000, 16'h02d0};
    cases[8] = '{2'h0, 1'b1, 8'h80, 16'h03e8, 16'h01f4, 16'h0000, 16'h00e1};
    cases[9] = '{2'h0, 1'b1, 8'hff, 16'h03e8, 16'h03e8, 16'h0000, 16'h02ce};
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      xfer(1'b1, FACTORY, regs[i], 8'h00, 1'b0);
      chk({8'h00, rdata_out}, {8'h00, rexp[i]}, 0);
    end
    xfer(1'b0, FACTORY ^ 7'h01, `HAG_REG_CONF, 8'h00, 1'b1);
    $display("test reset values and factory address done");
    for (int i = 0; i < 10; i++) begin
      xfer(1'b0, FACTORY, `HAG_REG_CONF, {6'h00, cases[i].pair}, 1'b0);
      xfer(1'b0, FACTORY, `HAG_REG_GAIN_SETUP, {7'h00, cases[i].tgt}, 1'b0);
      xfer(1'b0, FACTORY, `HAG_REG_GAIN_CODE, cases[i].code, 1'b0);
      sample(cases[i].x, cases[i].y, cases[i].z);
      chk({15'h0000, seen}, 16'h0001, 0);
      chk(angle_out, cases[i].ang, 8);
      xfer(1'b1, FACTORY, `HAG_REG_ANGLE_HI, 8'h00, 1'b0);
      hi = rdata_out;
      xfer(1'b1, FACTORY, `HAG_REG_ANGLE_LO, 8'h00, 1'b0);
      chk({hi, rdata_out}, cases[i].ang, 8);
    end
    $display("test angle pairs and gain done");
    @(posedge clock_in);
    x_in <= 16'h1234;
    xfer(1'b1, FACTORY, `HAG_REG_X_LO, 8'h00, 1'b0);
    chk({8'h00, rdata_out}, 16'h00e8, 0);
    xfer(1'b0, FACTORY, `HAG_REG_CONF, {6'h00, `HAG_PAIR_OFF}, 1'b0);
    sample(16'h0123, 16'h0000, 16'h0000);
    chk(angle_out, cases[9].ang, 8);
    xfer(1'b1, FACTORY, `HAG_REG_X_LO, 8'h00, 1'b0);
    chk({8'h00, rdata_out}, 16'h0023, 0);
    chk({15'h0000, int_seen_out}, 16'h0000, 0);
    $display("test result update timing done");
    xfer(1'b0, FACTORY, `HAG_REG_CONF, 8'h04, 1'b0);
    sample(16'h03e8, 16'h0000, 16'h0000);
    chk({15'h0000, int_seen_out}, 16'h0001, 0);
    repeat (120) @(negedge clock_in);
    chk({15'h0000, int_seen_out}, 16'h0000, 0);
    $display("test interrupt done");
    xfer(1'b0, FACTORY, `HAG_REG_BUS_ADDR, 8'h7f, 1'b0);
    chk({9'h000, bus_addr_out}, 16'h007f, 0);
    xfer(1'b1, 7'h7f, `HAG_REG_BUS_ADDR, 8'h00, 1'b0);
    chk({8'h00, rdata_out}, 16'h007f, 0);
    xfer(1'b1, FACTORY, `HAG_REG_CONF, 8'h00, 1'b1);
    @(posedge clock_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (5) @(negedge clock_in);
    chk({9'h000, bus_addr_out}, {9'h000, FACTORY}, 0);
    xfer(1'b1, 7'h7f, `HAG_REG_CONF, 8'h00, 1'b1);
    xfer(1'b1, FACTORY, `HAG_REG_CONF, 8'h00, 1'b0);
    chk({8'h00, rdata_out}, 16'h0000, 0);
    $display("test address programming done");
    close_out();
  end
endmodule // hall_angle_gain_and_addressing_bench
